// [src/rgc_pkg.sv]
// Purpose: shared constants for the reciprocal gate counter
// Assumes: 20 MHz system clock, register port with one-cycle read latency
// Notes:   all offsets are word indexes on the plain register port
package rgc_pkg;
	// =========================================================
	// clock and timing
	localparam int unsigned CLK_HZ          = 20000000;
	localparam int unsigned TB_NOM_HZ       = 10000000;
	localparam int unsigned EXT_LO_HZ       = 5000000;
	localparam int unsigned EXT_HI_HZ       = 10000000;
	localparam int unsigned DET_WIN_US      = 100;
	localparam int unsigned DET_WIN_CYC     = CLK_HZ / 1000000 * DET_WIN_US;
	localparam int unsigned TOL_PCT         = 10;
	localparam int unsigned EXT_LO_EDGES    = EXT_LO_HZ / 1000000 * DET_WIN_US;
	localparam int unsigned EXT_HI_EDGES    = EXT_HI_HZ / 1000000 * DET_WIN_US;
	localparam int unsigned ACT_HOLD_MS     = 100;
	localparam int unsigned ACT_HOLD_CYC    = CLK_HZ / 1000 * ACT_HOLD_MS;
	localparam int unsigned CTRL_TIME_DEF   = TB_NOM_HZ; // 1 s of timebase
	// =========================================================
	// register word offsets
	localparam logic [3:0] A_CTRL   = 4'h0;
	localparam logic [3:0] A_STAT   = 4'h1;
	localparam logic [3:0] A_CTIME  = 4'h2;
	localparam logic [3:0] A_EVCNT  = 4'h3;
	localparam logic [3:0] A_REFCNT = 4'h4;
	localparam logic [3:0] A_INT1   = 4'h5;
	localparam logic [3:0] A_INT2   = 4'h6;
	localparam logic [3:0] A_UPPER  = 4'h7;
	localparam logic [3:0] A_LOWER  = 4'h8;
	localparam logic [3:0] A_MEAS   = 4'h9;
	localparam logic [3:0] A_ISTAT  = 4'ha;
	localparam logic [3:0] A_IEN    = 4'hb;
	localparam logic [3:0] A_ICLR   = 4'hc;
	// =========================================================
	// control bits
	localparam int unsigned C_ARM    = 0; // write 1 to arm, self clearing
	localparam int unsigned C_GSRC   = 1; // gate_source_select: 1 = ext arm
	localparam int unsigned C_LIMEN  = 2;
	localparam int unsigned C_ABORT  = 3; // write 1 to abort
	// status bits
	localparam int unsigned S_GATE   = 0;
	localparam int unsigned S_BUSY   = 1;
	localparam int unsigned S_DONE   = 2;
	localparam int unsigned S_EXTTB  = 3;
	localparam int unsigned S_EXT10  = 4;
	localparam int unsigned S_LIMIT  = 5;
	localparam int unsigned S_ACT1   = 6;
	localparam int unsigned S_ACT2   = 7;
	// interrupt bits
	localparam int unsigned I_DONE   = 0;
	localparam int unsigned I_OPEN   = 1;
	localparam int unsigned I_REFCHG = 2;
	localparam int unsigned I_LIMIT  = 3;
	localparam int unsigned NIRQ     = 4;
	// reset values
	localparam logic [31:0] UPPER_RST = 32'hffffffff;
	localparam logic [31:0] LOWER_RST = 32'h00000000;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_ARMED = 4'b0010,
		ST_OPEN  = 4'b0100,
		ST_CLOSE = 4'b1000
	} rgc_state_e;
endpackage

// [src/rgc_refdet.sv]
// Purpose: detects an external 5 or 10 MHz reference and picks the timebase
// Assumes: ext ref already sampled into clk_sys, internal tick is 10 MHz
// Notes:   edge count over a fixed window, tolerance band on each frequency
`timescale 1ns/1ps
module rgc_refdet
	import rgc_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic reset_n,
	input  wire logic clk_en,
	input  wire logic ref_in,
	input  wire logic int_tick,
	output logic      tb_tick,
	output logic      ext_sel,
	output logic      ext_is10
);
	typedef struct packed {
		logic [15:0] win;
		logic [15:0] edges;
		logic        ref_d;
		logic        ext;
		logic        is10;
	} rgc_det_s;

	rgc_det_s q, d;
	logic ref_rise;
	logic lo_ok;
	logic hi_ok;

	// =========================================================
	// window counter, band check and tick select
	function automatic logic in_band(input logic [15:0] n,
		input int unsigned nom);
		in_band = (32'(n) * 100 >= nom * (100 - TOL_PCT)) &&
			(32'(n) * 100 <= nom * (100 + TOL_PCT));
	endfunction

	always_comb
	begin
		d = q;
		ref_rise = ref_in & ~q.ref_d;
		lo_ok = in_band(q.edges, EXT_LO_EDGES);
		hi_ok = in_band(q.edges, EXT_HI_EDGES);
		d.ref_d = ref_in;
		if (ref_rise)
			d.edges = q.edges + 16'h0001;
		if (q.win == 16'(DET_WIN_CYC - 1))
		begin
			d.win = 16'h0000;
			d.edges = 16'h0000;
			d.ext = lo_ok | hi_ok;
			d.is10 = hi_ok;
		end
		else
			d.win = q.win + 16'h0001;
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			q <= '0;
		else if (clk_en)
			q <= d;
	end

	// 10 MHz ext: every rising edge; 5 MHz ext: both edges; else internal
	assign tb_tick = !q.ext ? int_tick :
		q.is10 ? ref_rise : (ref_in ^ q.ref_d);
	assign ext_sel = q.ext;
	assign ext_is10 = q.is10;
endmodule

// [src/rgc_core.sv]
// Purpose: reciprocal gate counter core with register port and indicators
// Assumes: inputs synchronous to clk_sys, one write or read strobe a cycle
// Notes:   interpolator intervals arrive from an outside converter
`timescale 1ns/1ps
module rgc_core
	import rgc_pkg::*;
#(
	parameter int unsigned CW        = 32,
	parameter int unsigned ACT_HOLD  = ACT_HOLD_CYC,
	parameter logic [31:0] CTIME_RST = CTRL_TIME_DEF
)
(
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic        clk_en,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic        meas_in,
	input  wire logic        first_input_channel,
	input  wire logic        second_input_channel,
	input  wire logic        ext_arm_in,
	input  wire logic        ref_in,
	input  wire logic        int_osc_tick,
	input  wire logic [31:0] interp_start,
	input  wire logic [31:0] interp_stop,
	input  wire logic        interp_valid,
	output logic             ref_out,
	output logic             gate_flag,
	output logic             external_timebase_flag,
	output logic             limit_flag,
	output logic             first_activity_flag,
	output logic             second_activity_flag,
	output logic             irq
);
	typedef struct packed {
		rgc_state_e       st;
		logic             gsrc;
		logic             limen;
		logic [31:0]      ctime;
		logic [31:0]      timer;
		logic [CW-1:0]    ev;
		logic [CW-1:0]    rf;
		logic [CW-1:0]    ev_sv;
		logic [CW-1:0]    rf_sv;
		logic [31:0]      i1;
		logic [31:0]      i2;
		logic [31:0]      upper;
		logic [31:0]      lower;
		logic [31:0]      meas;
		logic             limit;
		logic             done;
		logic [NIRQ-1:0]  ist;
		logic [NIRQ-1:0]  ien;
		logic             meas_d;
		logic             arm_d;
		logic [2:0]       ch_d;
		logic [31:0]      act1;
		logic [31:0]      act2;
		logic             ext_d;
		logic             refo;
		logic [31:0]      rdata;
	} rgc_core_s;

	rgc_core_s q, d;
	logic tb_tick;
	logic ext_sel;
	logic ext_is10;
	logic meas_rise;
	logic arm_rise;
	logic expire;
	logic [NIRQ-1:0] ev_set;
	logic [NIRQ-1:0] clr;
	logic wr_ctrl;
	logic wr_clr;

	// =========================================================
	// timebase selection
	rgc_refdet u_det
	(
		.clk_sys  (clk_sys),
		.reset_n  (reset_n),
		.clk_en   (clk_en),
		.ref_in   (ref_in),
		.int_tick (int_osc_tick),
		.tb_tick  (tb_tick),
		.ext_sel  (ext_sel),
		.ext_is10 (ext_is10)
	);

	function automatic logic [31:0] zext(input logic [CW-1:0] v);
		zext = 32'(v);
	endfunction

	// =========================================================
	// next-state logic
	always_comb
	begin
		d = q;
		ev_set = '0;
		meas_rise = meas_in & ~q.meas_d;
		arm_rise = ext_arm_in & ~q.arm_d;
		wr_ctrl = reg_wr && reg_addr == A_CTRL;
		wr_clr = reg_wr && reg_addr == A_ICLR;
		clr = wr_clr ? reg_wdata[NIRQ-1:0] : '0;
		d.meas_d = meas_in;
		d.arm_d = ext_arm_in;
		d.ext_d = ext_sel;
		// internal timer expires by count, external source by arm edge
		expire = q.gsrc ? arm_rise : (q.timer == 32'h00000000);

		// register writes
		if (reg_wr)
		begin
			unique case (reg_addr)
				A_CTRL:
				begin
					d.gsrc = reg_wdata[C_GSRC];
					d.limen = reg_wdata[C_LIMEN];
				end
				A_CTIME: d.ctime = reg_wdata;
				A_UPPER: d.upper = reg_wdata;
				A_LOWER: d.lower = reg_wdata;
				A_MEAS:  d.meas = reg_wdata;
				A_IEN:   d.ien = reg_wdata[NIRQ-1:0];
				default: ;
			endcase
		end

		// measurement sequence
		unique case (q.st)
			ST_IDLE:
				if (wr_ctrl && reg_wdata[C_ARM])
				begin
					d.st = ST_ARMED;
					d.done = 1'b0;
					d.timer = q.ctime;
				end
			ST_ARMED:
				if (meas_rise && (!q.gsrc || arm_rise || q.arm_d))
				begin
					d.st = ST_OPEN;
					d.ev = '0;
					d.rf = '0;
					d.timer = q.ctime;
					ev_set[I_OPEN] = 1'b1;
				end
			ST_OPEN:
			begin
				if (meas_rise)
					d.ev = q.ev + 1'b1;
				if (tb_tick)
					d.rf = q.rf + 1'b1;
				if (tb_tick && q.timer != 32'h00000000)
					d.timer = q.timer - 32'h00000001;
				if (expire)
					d.st = ST_CLOSE;
			end
			ST_CLOSE:
			begin
				if (tb_tick)
					d.rf = q.rf + 1'b1;
				// apart from an abort write, closes only on an input edge, so the event count is exact
				if (meas_rise)
				begin
					d.st = ST_IDLE;
					d.ev_sv = q.ev + 1'b1;
					d.rf_sv = q.rf;
					d.done = 1'b1;
					ev_set[I_DONE] = 1'b1;
				end
			end
		endcase
		if (wr_ctrl && reg_wdata[C_ABORT])
			d.st = ST_IDLE;

		// interpolation intervals from converter
		if (interp_valid)
		begin
			d.i1 = interp_start;
			d.i2 = interp_stop;
		end

		// limit test on processor-computed value
		d.limit = q.limen && (q.meas > q.upper || q.meas < q.lower);
		if (d.limit && !q.limit)
			ev_set[I_LIMIT] = 1'b1;
		if (ext_sel != q.ext_d)
			ev_set[I_REFCHG] = 1'b1;

		// sticky status, set wins over clear
		d.ist = (q.ist & ~clr) | ev_set;

		// activity: hold after each input change
		d.ch_d = {second_input_channel, first_input_channel, 1'b0};
		if (first_input_channel != q.ch_d[1])
			d.act1 = 32'(ACT_HOLD);
		else if (q.act1 != 32'h00000000)
			d.act1 = q.act1 - 32'h00000001;
		if (second_input_channel != q.ch_d[2])
			d.act2 = 32'(ACT_HOLD);
		else if (q.act2 != 32'h00000000)
			d.act2 = q.act2 - 32'h00000001;

		// 10 MHz standard out: toggle each 20 MHz cycle
		d.refo = ~q.refo;

		// read data, valid the cycle after the strobe
		d.rdata = 32'h00000000;
		if (reg_rd)
		begin
			unique case (reg_addr)
				A_CTRL:   d.rdata = {29'h0, q.limen, q.gsrc, 1'b0};
				A_STAT:   d.rdata = {24'h0, q.act2 != 32'h0,
					q.act1 != 32'h0, q.limit, ext_is10, ext_sel,
					q.done, q.st != ST_IDLE, q.st[2] | q.st[3]};
				A_CTIME:  d.rdata = q.ctime;
				A_EVCNT:  d.rdata = zext(q.ev_sv);
				A_REFCNT: d.rdata = zext(q.rf_sv);
				A_INT1:   d.rdata = q.i1;
				A_INT2:   d.rdata = q.i2;
				A_UPPER:  d.rdata = q.upper;
				A_LOWER:  d.rdata = q.lower;
				A_MEAS:   d.rdata = q.meas;
				A_ISTAT:  d.rdata = 32'(q.ist);
				A_IEN:    d.rdata = 32'(q.ien);
				default:  d.rdata = 32'h00000000;
			endcase
		end
	end

	// =========================================================
	// state register
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			q <= '0;
			q.st <= ST_IDLE;
			q.ctime <= CTIME_RST;
			q.upper <= UPPER_RST;
			q.lower <= LOWER_RST;
		end
		else if (clk_en)
			q <= d;
	end

	// =========================================================
	// outputs
	assign reg_rdata = q.rdata;
	assign gate_flag = q.st[2] | q.st[3];
	assign external_timebase_flag = ext_sel;
	assign limit_flag = q.limit;
	assign first_activity_flag = q.act1 != 32'h0;
	assign second_activity_flag = q.act2 != 32'h0;
	assign ref_out = q.refo;
	assign irq = |(q.ist & q.ien);
endmodule

// [test/rgc_core_monitor.sv]
// Purpose: port checker for rgc_core
// Assumes: one clock domain, clk_sys
// Notes:   bound to rgc_core below the module
`timescale 1ns/1ps
module rgc_core_monitor
	import rgc_pkg::*;
#(
	parameter int unsigned ACT_HOLD = ACT_HOLD_CYC
)
(
	input wire logic        clk_sys,
	input wire logic        reset_n,
	input wire logic        clk_en,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic        meas_in,
	input wire logic        ref_in,
	input wire logic        first_input_channel,
	input wire logic        second_input_channel,
	input wire logic        ref_out,
	input wire logic        gate_flag,
	input wire logic        external_timebase_flag,
	input wire logic        first_activity_flag,
	input wire logic        second_activity_flag
);
	logic [31:0] rq_q;
	logic [31:0] aq_q;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// =====================================================
	// quiet cycles of the reference and of channel one
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			{rq_q, aq_q} <= 64'h0;
		else
			{rq_q, aq_q} <= {$changed(ref_in) ? 32'h0 : rq_q + 32'h1,
				$changed(first_input_channel) ? 32'h0 : aq_q + 32'h1};
	end
	// reference output toggles every running cycle
	AST_REF_OUT: assert property
		($past(clk_en) && $past(reset_n) |-> ref_out != $past(ref_out))
		else $error("reference output stuck");
	// read data only in the cycle after a read strobe
	AST_RD_IDLE: assert property
		(clk_en && !reg_rd |=> reg_rdata == 32'h0)
		else $error("read data outside its cycle");
	// gate opens one cycle after a measured rising edge
	AST_OPEN: assert property
		($rose(gate_flag) |-> $past(meas_in) && !$past(meas_in, 2))
		else $error("gate opened off an input edge");
	// gate closes on an input edge or an abort write
	AST_CLOSE: assert property
		($fell(gate_flag) |-> $past(reg_wr) ||
			($past(meas_in) && !$past(meas_in, 2)))
		else $error("gate closed off an input edge");
	// a silent reference cannot hold the external timebase
	AST_EXT_OFF: assert property
		(rq_q > 3 * DET_WIN_CYC |-> !external_timebase_flag)
		else $error("external timebase without reference");
	AST_ACT1: assert property
		($rose(first_input_channel) |-> ##[1:4] first_activity_flag)
		else $error("channel one activity missed");
	AST_ACT2: assert property
		($rose(second_input_channel) |-> ##[1:4] second_activity_flag)
		else $error("channel two activity missed");
	AST_ACT_DROP: assert property
		(aq_q > ACT_HOLD + 8 |-> !first_activity_flag)
		else $error("channel one activity held too long");
endmodule
bind rgc_core rgc_core_monitor #(.ACT_HOLD(ACT_HOLD)) i_rgc_core_monitor
(
	.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.meas_in(meas_in), .ref_in(ref_in), .ref_out(ref_out),
	.first_input_channel(first_input_channel),
	.second_input_channel(second_input_channel), .gate_flag(gate_flag),
	.external_timebase_flag(external_timebase_flag),
	.first_activity_flag(first_activity_flag),
	.second_activity_flag(second_activity_flag)
);

// [test/rgc_proc_model.sv]
// Purpose: processor model on the register port of rgc_core
// Assumes: one access at a time
// Notes:   strobes change only just after a rising edge
`timescale 1ns/1ps
module rgc_proc_model
	import rgc_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic [31:0] reg_rdata,
	output logic      [3:0]  reg_addr,
	output logic      [31:0] reg_wdata,
	output logic             reg_wr,
	output logic             reg_rd
);
	// =====================================================
	// idle bus at time zero
	initial
	begin
		{reg_addr, reg_wdata, reg_wr, reg_rd} = 38'h0;
	end
	// one-cycle write strobe
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		{reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	// fetch of any register word, taken a cycle later
	task rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		{reg_addr, reg_rd} <= {a, 1'b1};
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(posedge clk_sys);
		d = reg_rdata;
	endtask
	// control time reloaded before every arm
	task arm(input logic [31:0] t, input logic ext);
		wr(A_CTIME, t);
		wr(A_CTRL, {30'h0, ext, 1'b1});
	endtask
endmodule

// [test/rgc_core_tb.sv]
// Purpose: self-checking bench for rgc_core
// Assumes: clk_en held high, activity hold cut to 50 cycles
// Notes:   register traffic goes through rgc_proc_model
`timescale 1ns/1ps
module rgc_core_tb
	import rgc_pkg::*;
();
	logic        clk_sys, reset_n, clk_en, meas_in, ext_arm_in, ref_in;
	logic        first_input_channel, second_input_channel, int_osc_tick;
	logic        interp_valid, reg_wr, reg_rd, meas_run, ref_out, irq;
	logic        gate_flag, external_timebase_flag, limit_flag;
	logic        first_activity_flag, second_activity_flag;
	logic [31:0] interp_start, interp_stop, reg_wdata, reg_rdata;
	logic [3:0]  reg_addr, meas_cnt;
	logic [1:0]  ref_mode;
	int          fails, total_checks;
	// =====================================================
	// design and processor model
	rgc_core #(.ACT_HOLD(50)) i_rgc_core
	(
		.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .meas_in(meas_in),
		.first_input_channel(first_input_channel),
		.second_input_channel(second_input_channel),
		.ext_arm_in(ext_arm_in), .ref_in(ref_in),
		.int_osc_tick(int_osc_tick), .interp_start(interp_start),
		.interp_stop(interp_stop), .interp_valid(interp_valid),
		.ref_out(ref_out), .gate_flag(gate_flag), .irq(irq),
		.external_timebase_flag(external_timebase_flag),
		.limit_flag(limit_flag),
		.first_activity_flag(first_activity_flag),
		.second_activity_flag(second_activity_flag)
	);
	rgc_proc_model i_rgc_proc_model
	(
		.clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd)
	);
	// 50 ns clock
	initial
	begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	// 10 MHz tick, input edge every 16 cycles, 10 or 5 MHz reference
	always @(posedge clk_sys)
	begin
		if (!reset_n)
			{int_osc_tick, meas_cnt, meas_in, ref_in} <= 7'h0;
		else
		begin
			int_osc_tick <= ~int_osc_tick;
			meas_cnt <= meas_cnt + {3'h0, meas_run};
			meas_in <= meas_cnt[3];
			ref_in <= ref_in ^ (ref_mode[0] | (ref_mode[1] & int_osc_tick));
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task chkb(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task wait_gate(input logic lvl);
		repeat (3000)
		begin
			tick(1);
			if (gate_flag === lvl)
				return;
		end
		fails++;
		print_verdict();
	endtask
	task t_regs();
		logic [31:0] d;
		chkb(gate_flag, 1'b0);
		i_rgc_proc_model.rd(A_CTIME, d);
		chk(d, CTRL_TIME_DEF);
		i_rgc_proc_model.wr(4'hd, 32'h5a5a5a5a);
		i_rgc_proc_model.rd(4'hd, d);
		chk(d, 32'h0);
	endtask
	task t_meas(input logic ext);
		logic [31:0] d;
		logic [31:0] ev;
		ev = ext ? 32'h1 : 32'h3;
		ext_arm_in <= ext;
		i_rgc_proc_model.wr(A_IEN, 32'h1);
		i_rgc_proc_model.arm(32'd20, ext);
		meas_run <= 1'b1;
		wait_gate(1'b1);
		if (ext)
		begin
			tick(8);
			ext_arm_in <= 1'b0;
			tick(1);
			ext_arm_in <= 1'b1;
		end
		wait_gate(1'b0);
		tick(1);
		chkb(irq, 1'b1);
		{interp_start, interp_stop, interp_valid} <= {ev, 32'h9, 1'b1};
		i_rgc_proc_model.rd(A_EVCNT, d);
		interp_valid <= 1'b0;
		chk(d, ev);
		i_rgc_proc_model.rd(A_REFCNT, d);
		chkb(d + 32'h1 >= ev * 8 && d <= ev * 8 + 1, 1'b1);
		i_rgc_proc_model.rd(A_INT1, d);
		chk(d, ev);
		i_rgc_proc_model.rd(A_INT2, d);
		chk(d, 32'h9);
		i_rgc_proc_model.wr(A_ICLR, 32'hf);
		tick(1);
		chkb(irq, 1'b0);
		meas_run <= 1'b0;
	endtask
	// abort write drops an open gate back to idle
	task t_abort();
		logic [31:0] d;
		i_rgc_proc_model.arm(32'd20, 1'b0);
		meas_run <= 1'b1;
		wait_gate(1'b1);
		i_rgc_proc_model.wr(A_CTRL, 32'h8);
		tick(1);
		chkb(gate_flag, 1'b0);
		i_rgc_proc_model.rd(A_STAT, d);
		chk(d & 32'h3, 32'h0);
		meas_run <= 1'b0;
	endtask
	task t_limit();
		logic [31:0] mv [4] = '{32'd200, 32'd50, 32'd9, 32'd9};
		i_rgc_proc_model.wr(A_UPPER, 32'd100);
		i_rgc_proc_model.wr(A_LOWER, 32'd10);
		foreach (mv[i])
		begin
			i_rgc_proc_model.wr(A_MEAS, mv[i]);
			i_rgc_proc_model.wr(A_CTRL, {29'h0, i < 3, 2'h0});
			tick(3);
			chkb(limit_flag, i != 1 && i < 3);
		end
	endtask
	task t_act();
		repeat (4)
		begin
			tick(2);
			first_input_channel <= ~first_input_channel;
			second_input_channel <= ~second_input_channel;
		end
		tick(4);
		chk({30'h0, first_activity_flag, second_activity_flag},
			32'h3);
		tick(80);
		chk({30'h0, first_activity_flag, second_activity_flag},
			32'h0);
	endtask
	task t_ref();
		logic [31:0] d;
		logic [31:0] e;
		logic [1:0]  mode [3] = '{2'h1, 2'h0, 2'h2};
		// 10 MHz, then silence, then 5 MHz on the reference input
		for (int m = 0; m < 3; m++)
		begin
			ref_mode <= mode[m];
			tick(7000);
			e = {30'h0, mode[m] == 2'h1, mode[m] != 2'h0};
			i_rgc_proc_model.rd(A_STAT, d);
			chk(32'(d[S_EXT10:S_EXTTB]), e);
			chkb(external_timebase_flag, mode[m] != 2'h0);
		end
	endtask
	task print_verdict();
		$display("checks=%0d fails=%0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// reset for 12 cycles, then the scenarios
	initial
	begin
		{reset_n, ext_arm_in} = 2'h0;
		{first_input_channel, second_input_channel, interp_valid} = 3'h0;
		{meas_run, ref_mode, clk_en} = 4'h1;
		{interp_start, interp_stop, fails, total_checks} = 128'h0;
		repeat (12) @(posedge clk_sys);
		reset_n <= 1'b1;
		t_regs();
		t_meas(1'b0);
		t_meas(1'b1);
		t_abort();
		t_limit();
		t_act();
		t_ref();
		print_verdict();
	end
endmodule
